// file: design/pp_read_pkg.sv
// Functional notes
// - A read sequence that crosses into a new external page gets an address-latch cycle that reloads the upper bits first.
// - With hold disabled, a read cycle is followed directly by the next address-latch cycle, with no idle cycle between.
// - With bus_hold_cycle_enable set, every external read is followed by one hold cycle, invisible to software.
// - In 8-bit mode a burst of at most 256 bytes inside one page runs with no address-latch cycle after any read.
// - The upper address is driven on the multiplexed lines and captured by the falling latch strobe; memory must not drive then.
// - Boot fetches the image in 8-bit mode with consecutive reads, crossing pages with latch cycles as needed.
`default_nettype none
package pp_read_pkg;
  localparam int ADDR_W       = 24;
  localparam int PAGE_LSB     = 8;
  localparam int DATA_W       = 16;
  localparam int WAIT_W       = 4;
  localparam int LEN_W        = 16;
  localparam int FIFO_DEPTH   = 8;
  localparam int LATCH_CYC    = 2;
  localparam logic [WAIT_W-1:0] WAIT_RESET = 4'h0;
  localparam int HOLD_NS      = 5;
  localparam int CLK_MHZ      = 50;
  localparam int HOLD_CYC_RAW = (HOLD_NS * CLK_MHZ + 999) / 1000;
  localparam int HOLD_CYC     = (HOLD_CYC_RAW < 1) ? 1 : HOLD_CYC_RAW;
  localparam logic [ADDR_W-1:0] BOOT_ADDR = 24'h000000;
  localparam logic [LEN_W-1:0]  BOOT_LEN  = 16'h0400;
  localparam logic [WAIT_W-1:0] BOOT_WAIT = 4'h2;

  typedef enum logic [2:0] {
    ST_IDLE, ST_LATCH_HI, ST_LATCH_LO, ST_READ, ST_HOLD, ST_STALL
  } seq_state_type;

  function automatic logic [ADDR_W-PAGE_LSB-1:0] page_of(input logic [ADDR_W-1:0] a);
    page_of = a[ADDR_W-1:PAGE_LSB];
  endfunction
endpackage
`default_nettype wire

// file: design/pp_read_fifo.sv
`timescale 1ns/1ps
`default_nettype none
module pp_read_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 8
) (
  // Clock and reset
  input  wire logic             mclk_i,
  input  wire logic             reset_n_i,
  // Fill side
  input  wire logic             in_valid_i,
  input  wire logic [WIDTH-1:0] in_data_i,
  output logic                  in_ready_o,
  // Drain side
  output logic                  out_valid_o,
  output logic [WIDTH-1:0]      out_data_o,
  input  wire logic             out_ready_i
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic [AW-1:0]    wr_ptr_ff;
  logic [AW-1:0]    rd_ptr_ff;
  logic [AW:0]      count_ff;
  logic             push;
  logic             pop;

  // Read data straight from the register array
  assign push        = in_valid_i && (count_ff != (AW+1)'(DEPTH));
  assign pop         = out_ready_i && (count_ff != '0);
  assign in_ready_o  = count_ff != (AW+1)'(DEPTH);
  assign out_valid_o = count_ff != '0;
  assign out_data_o  = mem_ff[rd_ptr_ff];

  always_ff @(posedge mclk_i) begin
    if (push) begin
      mem_ff[wr_ptr_ff] <= in_data_i;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!reset_n_i) begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
      count_ff  <= '0;
    end else begin
      if (push) begin
        wr_ptr_ff <= (wr_ptr_ff == AW'(DEPTH-1)) ? '0 : wr_ptr_ff + 1'b1;
      end
      if (pop) begin
        rd_ptr_ff <= (rd_ptr_ff == AW'(DEPTH-1)) ? '0 : rd_ptr_ff + 1'b1;
      end
      count_ff <= count_ff + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule
`default_nettype wire

// file: design/pp_read_seq.sv
`timescale 1ns/1ps
`default_nettype none
module pp_read_seq
  import pp_read_pkg::*;
#(
  parameter int FDEPTH = FIFO_DEPTH
) (
  // Clock and reset
  input  wire logic              mclk_i,
  input  wire logic              reset_n_i,
  // Configuration levels
  input  wire logic              bus_hold_cycle_enable_i,
  input  wire logic              wide_mode_i,
  input  wire logic [WAIT_W-1:0] wait_states_i,
  input  wire logic              boot_i,
  // DMA request
  input  wire logic              start_i,
  input  wire logic [ADDR_W-1:0] start_addr_i,
  input  wire logic [LEN_W-1:0]  length_i,
  output logic                   busy_o,
  output logic                   done_o,
  // Read data stream
  output logic                   data_valid_o,
  output logic [DATA_W-1:0]      data_o,
  input  wire logic              data_ready_i,
  // External memory port
  input  wire logic [DATA_W-1:0] ad_in_i,
  output logic [DATA_W-1:0]      ad_out_o,
  output logic                   ad_oe_o,
  output logic                   latch_strobe_o,
  output logic                   mem_oe_n_o,
  output logic [PAGE_LSB-1:0]    addr_lo_o
);
  seq_state_type             state_ff;
  logic [ADDR_W-1:0]         addr_ff;
  logic [LEN_W-1:0]          left_ff;
  logic [ADDR_W-PAGE_LSB-1:0] page_ff;
  logic                      page_ok_ff;
  logic [WAIT_W-1:0]         wait_ff;
  logic [WAIT_W-1:0]         wait_cfg_ff;
  logic                      wide_ff;
  logic [2:0]                cnt_ff;
  logic                      boot_s1_ff;
  logic                      boot_s2_ff;
  logic                      boot_s3_ff;
  logic                      boot_done_ff;
  logic                      push;
  logic                      fifo_ready;
  logic                      fifo_valid;
  logic [DATA_W-1:0]         fifo_data;
  logic [ADDR_W-1:0]         nxt_addr;
  logic                      need_latch;
  logic [DATA_W-1:0]         rd_word;
  logic                      pins_ready;

  // Boot strap enters from a pin; three stages, acted on when the last two agree
  always_ff @(posedge mclk_i) begin
    if (!reset_n_i) begin
      boot_s1_ff <= 1'b0;
      boot_s2_ff <= 1'b0;
      boot_s3_ff <= 1'b0;
    end else begin
      boot_s1_ff <= boot_i;
      boot_s2_ff <= boot_s1_ff;
      boot_s3_ff <= boot_s2_ff;
    end
  end

  // Pins lag the state by a cycle; a read counts once they show its address with OE low
  assign pins_ready = !mem_oe_n_o && !ad_oe_o && (addr_lo_o == addr_ff[PAGE_LSB-1:0]);
  assign nxt_addr   = addr_ff + (wide_ff ? ADDR_W'(2) : ADDR_W'(1));
  assign need_latch = page_of(nxt_addr) != page_ff;
  // Memory data shares the port clock, so no synchroniser
  assign rd_word    = wide_ff ? ad_in_i : {8'h00, ad_in_i[7:0]};
  assign push       = (state_ff == ST_READ) && (wait_ff == '0) && pins_ready;

  always_ff @(posedge mclk_i) begin
    if (!reset_n_i) begin
      state_ff     <= ST_IDLE;
      addr_ff      <= '0;
      left_ff      <= '0;
      page_ff      <= '0;
      page_ok_ff   <= 1'b0;
      wait_ff      <= '0;
      wait_cfg_ff  <= WAIT_RESET;
      wide_ff      <= 1'b0;
      cnt_ff       <= '0;
      boot_done_ff <= 1'b0;
      done_o       <= 1'b0;
    end else begin
      done_o <= 1'b0;
      case (state_ff)
        ST_IDLE: begin
          if (boot_s2_ff && boot_s3_ff && !boot_done_ff) begin
            // Boot: 8-bit, consecutive reads over pages
            boot_done_ff <= 1'b1;
            addr_ff      <= BOOT_ADDR;
            left_ff      <= BOOT_LEN;
            wide_ff      <= 1'b0;
            wait_cfg_ff  <= BOOT_WAIT;
            state_ff     <= ST_LATCH_HI;
            cnt_ff       <= '0;
          end else if (start_i && length_i != '0) begin
            addr_ff     <= start_addr_i;
            left_ff     <= length_i;
            wide_ff     <= wide_mode_i;
            wait_cfg_ff <= wait_states_i;
            // Page already in the latch skips the strobe
            state_ff    <= (page_ok_ff && page_of(start_addr_i) == page_ff) ? ST_READ : ST_LATCH_HI;
            wait_ff     <= wait_states_i;
            cnt_ff      <= '0;
          end
        end
        ST_LATCH_HI: begin
          // Upper bits driven while the strobe is high
          if (cnt_ff == 3'(LATCH_CYC - 1)) begin
            state_ff <= ST_LATCH_LO;
            cnt_ff   <= '0;
          end else begin
            cnt_ff <= cnt_ff + 1'b1;
          end
        end
        ST_LATCH_LO: begin
          page_ff    <= page_of(addr_ff);
          page_ok_ff <= 1'b1;
          wait_ff    <= wait_cfg_ff;
          state_ff   <= ST_READ;
        end
        ST_READ: begin
          if (!pins_ready) begin
            // Wait states count only while the pins present this read
            cnt_ff <= '0;
          end else if (wait_ff != '0) begin
            wait_ff <= wait_ff - 1'b1;
          end else if (!fifo_ready) begin
            state_ff <= ST_STALL;
          end else begin
            addr_ff <= nxt_addr;
            left_ff <= left_ff - 1'b1;
            wait_ff <= wait_cfg_ff;
            cnt_ff  <= '0;
            if (bus_hold_cycle_enable_i) begin
              state_ff <= ST_HOLD;
            end else if (left_ff == 16'h0001) begin
              state_ff <= ST_IDLE;
              done_o   <= 1'b1;
            end else if (need_latch) begin
              state_ff <= ST_LATCH_HI;
            end else begin
              state_ff <= ST_READ;
            end
          end
        end
        ST_STALL: begin
          if (fifo_ready) begin
            // OE was released, so the full access time starts again
            state_ff <= ST_READ;
            wait_ff  <= wait_cfg_ff;
          end
        end
        ST_HOLD: begin
          if (cnt_ff == 3'(HOLD_CYC - 1)) begin
            cnt_ff <= '0;
            if (left_ff == '0) begin
              state_ff <= ST_IDLE;
              done_o   <= 1'b1;
            end else begin
              state_ff <= (page_of(addr_ff) != page_ff) ? ST_LATCH_HI : ST_READ;
            end
          end else begin
            cnt_ff <= cnt_ff + 1'b1;
          end
        end
        default: state_ff <= ST_IDLE;
      endcase
    end
  end

  // Pin drivers registered; stall keeps OE off with the bus released
  always_ff @(posedge mclk_i) begin
    if (!reset_n_i) begin
      ad_out_o       <= '0;
      ad_oe_o        <= 1'b0;
      latch_strobe_o <= 1'b0;
      mem_oe_n_o     <= 1'b1;
      addr_lo_o      <= '0;
      busy_o         <= 1'b0;
    end else begin
      busy_o         <= state_ff != ST_IDLE;
      latch_strobe_o <= state_ff == ST_LATCH_HI;
      ad_oe_o        <= state_ff == ST_LATCH_HI || state_ff == ST_LATCH_LO;
      ad_out_o       <= DATA_W'(page_of(addr_ff));
      addr_lo_o      <= addr_ff[PAGE_LSB-1:0];
      mem_oe_n_o     <= !(state_ff == ST_READ && !(push && !fifo_ready));
    end
  end

  pp_read_fifo #(
    .WIDTH (DATA_W),
    .DEPTH (FDEPTH)
  ) u_fifo (
    .mclk_i      (mclk_i),
    .reset_n_i   (reset_n_i),
    .in_valid_i  (push && fifo_ready),
    .in_data_i   (rd_word),
    .in_ready_o  (fifo_ready),
    .out_valid_o (fifo_valid),
    .out_data_o  (fifo_data),
    .out_ready_i (data_ready_i || !data_valid_o)
  );

  // Output stage register so the stream ports come from flops
  always_ff @(posedge mclk_i) begin
    if (!reset_n_i) begin
      data_valid_o <= 1'b0;
      data_o       <= '0;
    end else if (data_ready_i || !data_valid_o) begin
      data_valid_o <= fifo_valid;
      data_o       <= fifo_data;
    end
  end

  // Strobe falls only after the upper address was driven
  property p_latch_fall;
    @(posedge mclk_i) disable iff (!reset_n_i)
      $fell(latch_strobe_o) |-> ad_oe_o && mem_oe_n_o;
  endproperty
  a_latch_fall: assert property (p_latch_fall) else $error("latch strobe fell without address drive");

  // Output enable never overlaps a latch cycle
  property p_oe_excl;
    @(posedge mclk_i) disable iff (!reset_n_i)
      !mem_oe_n_o |-> !ad_oe_o && !latch_strobe_o;
  endproperty
  a_oe_excl: assert property (p_oe_excl) else $error("output enable overlaps latch cycle");

  // Hold option puts a hold cycle after each read
  property p_hold;
    @(posedge mclk_i) disable iff (!reset_n_i)
      push && fifo_ready && bus_hold_cycle_enable_i |=> state_ff == ST_HOLD;
  endproperty
  a_hold: assert property (p_hold) else $error("missing hold cycle");

  // No hold: read goes straight to latch on a page change
  property p_direct;
    @(posedge mclk_i) disable iff (!reset_n_i)
      push && fifo_ready && !bus_hold_cycle_enable_i && need_latch && left_ff != 16'h0001
        |=> state_ff == ST_LATCH_HI;
  endproperty
  a_direct: assert property (p_direct) else $error("read not followed by latch on page change");

  // Same page keeps reading without a latch cycle
  property p_same_page;
    @(posedge mclk_i) disable iff (!reset_n_i)
      push && fifo_ready && !bus_hold_cycle_enable_i && !need_latch && left_ff != 16'h0001
        |=> state_ff == ST_READ;
  endproperty
  a_same_page: assert property (p_same_page) else $error("latch inserted inside a page");

  // Latch sequence length is fixed
  property p_latch_len;
    @(posedge mclk_i) disable iff (!reset_n_i)
      $rose(state_ff == ST_LATCH_HI) |-> ##2 state_ff == ST_LATCH_LO ##1 state_ff == ST_READ;
  endproperty
  a_latch_len: assert property (p_latch_len) else $error("latch sequence length wrong");

  // Boot runs byte wide
  property p_boot_width;
    @(posedge mclk_i) disable iff (!reset_n_i)
      state_ff == ST_IDLE && boot_s2_ff && boot_s3_ff && !boot_done_ff |=> !wide_ff && busy_o == 1'b0 ##1 busy_o;
  endproperty
  a_boot_width: assert property (p_boot_width) else $error("boot not in 8-bit mode");

  // Latched page follows the address after a latch
  property p_page_track;
    @(posedge mclk_i) disable iff (!reset_n_i)
      state_ff == ST_LATCH_LO |=> page_ff == page_of(addr_ff);
  endproperty
  a_page_track: assert property (p_page_track) else $error("latched page mismatch");

  // Strobe rises only with the output enable off and the port driving
  property p_strobe_oe_off;
    @(posedge mclk_i) disable iff (!reset_n_i)
      $rose(latch_strobe_o) |-> mem_oe_n_o && ad_oe_o;
  endproperty
  a_strobe_oe_off: assert property (p_strobe_oe_off) else $error("latch strobe rose during a read");

  // Output enable only follows a read state
  property p_oe_read;
    @(posedge mclk_i) disable iff (!reset_n_i)
      !mem_oe_n_o |-> $past(state_ff == ST_READ);
  endproperty
  a_oe_read: assert property (p_oe_read) else $error("output enable outside a read");

  // With hold on, the bus idles for a cycle once OE is released
  property p_hold_gap;
    @(posedge mclk_i) disable iff (!reset_n_i)
      $rose(mem_oe_n_o) && $past(bus_hold_cycle_enable_i, 2) |-> !ad_oe_o && !latch_strobe_o;
  endproperty
  a_hold_gap: assert property (p_hold_gap) else $error("no idle cycle after read with hold on");

  // Upper address stands on the lines while the strobe is high
  property p_latch_page;
    @(posedge mclk_i) disable iff (!reset_n_i)
      $rose(latch_strobe_o) |-> ad_out_o == DATA_W'(page_of(addr_ff));
  endproperty
  a_latch_page: assert property (p_latch_page) else $error("wrong upper address at latch");
endmodule
`default_nettype wire

// file: tb/pp_mem_model.sv
`timescale 1ns/1ps
`default_nettype none
module pp_mem_model
  import pp_read_pkg::*;
(
  // Port side
  input  wire logic                mclk_i,
  input  wire logic                reset_n_i,
  input  wire logic [DATA_W-1:0]   ad_out_i,
  input  wire logic                ad_oe_i,
  input  wire logic                latch_strobe_i,
  input  wire logic                mem_oe_n_i,
  input  wire logic [PAGE_LSB-1:0] addr_lo_i,
  // Resolved lines and contention count
  output logic [DATA_W-1:0]        ad_o,
  output int                       n_cont
);
  logic [DATA_W-1:0] page = 16'hffff;
  logic [DATA_W-1:0] last = 16'h0000;
  initial n_cont = 0;
  // Falling strobe captures the page; only the port may drive then
  always @(negedge latch_strobe_i) begin
    if (reset_n_i === 1'b1) begin
      page <= ad_out_i;
      if (mem_oe_n_i !== 1'b1 || ad_oe_i !== 1'b1) n_cont++;
    end
  end
  // Released lines flip every cycle so a stale sample never matches
  assign ad_o = ad_oe_i ? ad_out_i :
                (!mem_oe_n_i ? {page[7:0] ^ 8'h5a, addr_lo_i ^ page[7:0]} : ~last);
  always @(posedge mclk_i) last <= ad_o;
endmodule
`default_nettype wire

// file: tb/tb_parallel_port_dma_read_sequencer.sv
`timescale 1ns/1ps
`default_nettype none
module tb_parallel_port_dma_read_sequencer;
  import pp_read_pkg::*;
  logic                mclk_i = 1'b0;
  logic                reset_n_i = 1'b0;
  logic                hold_en = 1'b0;
  logic                wide = 1'b0;
  logic [WAIT_W-1:0]   ws = 4'h0;
  logic                boot = 1'b0;
  logic                start = 1'b0;
  logic [ADDR_W-1:0]   saddr = 24'h000000;
  logic [LEN_W-1:0]    len = 16'h0000;
  logic                rdy = 1'b1;
  logic                busy, done, dval, ad_oe, strobe, oe_n;
  logic [DATA_W-1:0]   dout, ad_in, ad_out;
  logic [PAGE_LSB-1:0] alo;
  logic                prev_oe_n = 1'b1;
  logic [DATA_W-1:0]   got[$];
  int                  n_fail = 0;
  int                  tests_run = 0;
  int                  n_lat = 0;
  int                  n_dir = 0;
  int                  n_ovl = 0;
  int                  n_done = 0;
  int                  cont;
  always #10 mclk_i = ~mclk_i;
  pp_read_seq dut (.mclk_i(mclk_i), .reset_n_i(reset_n_i), .bus_hold_cycle_enable_i(hold_en),
    .wide_mode_i(wide), .wait_states_i(ws), .boot_i(boot), .start_i(start), .start_addr_i(saddr),
    .length_i(len), .busy_o(busy), .done_o(done), .data_valid_o(dval), .data_o(dout),
    .data_ready_i(rdy), .ad_in_i(ad_in), .ad_out_o(ad_out), .ad_oe_o(ad_oe),
    .latch_strobe_o(strobe), .mem_oe_n_o(oe_n), .addr_lo_o(alo));
  pp_mem_model mem (.mclk_i(mclk_i), .reset_n_i(reset_n_i), .ad_out_i(ad_out), .ad_oe_i(ad_oe),
    .latch_strobe_i(strobe), .mem_oe_n_i(oe_n), .addr_lo_i(alo), .ad_o(ad_in), .n_cont(cont));
  always @(posedge mclk_i) begin
    if (dval === 1'b1 && rdy) got.push_back(dout);
    // Strobe rising straight out of a read: no turnaround cycle
    if (strobe === 1'b1 && prev_oe_n === 1'b0) n_dir++;
    if (oe_n === 1'b0 && (strobe !== 1'b0 || ad_oe !== 1'b0)) n_ovl++;
    if (done === 1'b1) n_done++;
    prev_oe_n <= oe_n;
  end
  always @(negedge strobe) if (reset_n_i === 1'b1) n_lat++;
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_fail++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic close_out();
    $display("Comparisons %0d, mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // Second start cycle carries another address and must be ignored
  task automatic go(input logic [ADDR_W-1:0] a, input logic [LEN_W-1:0] n, input logic w,
                    input logic h, input logic [WAIT_W-1:0] s);
    @(negedge mclk_i);
    saddr = a;
    len = n;
    wide = w;
    hold_en = h;
    ws = s;
    start = 1'b1;
    @(negedge mclk_i);
    saddr = a ^ 24'h000040;
    @(negedge mclk_i);
    start = 1'b0;
  endtask
  task automatic judge(input logic [ADDR_W-1:0] a0, input logic w, input int n, input int lat,
                       input logic dir);
    logic [ADDR_W-1:0] a;
    int k;
    k = 0;
    while (got.size() < n && k < 40000) begin
      @(negedge mclk_i);
      k++;
    end
    if (got.size() < n) begin
      check(got.size(), n);
      close_out();
    end
    repeat (8) @(negedge mclk_i);
    check(got.size(), n);
    for (int i = 0; i < n; i++) begin
      a = a0 + ADDR_W'(w ? 2 * i : i);
      check(got[i], {w ? a[15:8] ^ 8'h5a : 8'h00, a[7:0] ^ a[15:8]});
    end
    check(n_lat, lat);
    check(n_dir > 0, dir);
    check(n_done, 1);
    check(busy, 1'b0);
    check(cont, 0);
    check(n_ovl, 0);
    got.delete();
    n_lat = 0;
    n_dir = 0;
    n_done = 0;
  endtask
  task automatic t_in_page();
    go(24'h120000, 16'h0100, 1'b0, 1'b0, 4'h0);
    judge(24'h120000, 1'b0, 256, 1, 1'b0);
  endtask
  task automatic t_cross8();
    go(24'h3400f0, 16'h0028, 1'b0, 1'b0, 4'h0);
    judge(24'h3400f0, 1'b0, 40, 2, 1'b1);
  endtask
  // Sink stalls long enough for the buffer to fill and refuse
  task automatic t_wide_hold();
    rdy = 1'b0;
    go(24'h5601f0, 16'h0018, 1'b1, 1'b1, 4'h1);
    repeat (120) @(negedge mclk_i);
    check(dval, 1'b1);
    check(busy, 1'b1);
    rdy = 1'b1;
    judge(24'h5601f0, 1'b1, 24, 2, 1'b0);
  endtask
  task automatic t_boot();
    hold_en = 1'b0;
    boot = 1'b1;
    repeat (6) @(negedge mclk_i);
    boot = 1'b0;
    judge(BOOT_ADDR, 1'b0, 1024, 4, 1'b1);
  endtask
  initial begin
    repeat (6) @(negedge mclk_i);
    reset_n_i = 1'b1;
    t_in_page();
    t_cross8();
    t_wide_hold();
    t_boot();
    close_out();
  end
endmodule
`default_nettype wire
